// [hdl/ttcm_pkg.sv]
// constants and carrier types for the thermal throttle clock modulator
package ttcm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_ENGAGE_NS = 1000000;
  localparam int MIN_ENGAGE_CYC = (MIN_ENGAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HYST_NS = 50000;
  localparam int HYST_CYC = (HYST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_NS = 1000;
  localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADAPT_STEP_NS = 500000;
  localparam int ADAPT_STEP_CYC = (ADAPT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_THERM_STATUS = 4'h0;
  localparam logic [3:0] IDX_THERM_INT_CTL = 4'h1;
  localparam logic [3:0] IDX_CLK_MOD_CTL = 4'h2;
  localparam logic [3:0] IDX_MISC_ENABLE = 4'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_LOG_BIT = 1;
  localparam int IE_HIGH_BIT = 0;
  localparam int IE_LOW_BIT = 1;
  localparam int CM_DUTY_LSB = 1;
  localparam int CM_EN_BIT = 4;
  localparam int ME_DUTY_THR_BIT = 3;
  localparam int ME_ADAPT_BIT = 16;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam int NUM_LP = 2;
  localparam logic [2:0] CM_DUTY_RST = 3'h1;
  localparam logic [3:0] AUTO_DUTY_SLOTS = 4'h4;
  localparam logic [3:0] FULL_SLOTS = 4'h8;
  localparam logic [2:0] OP_POINT_TOP = 3'h7;
  localparam logic [2:0] OP_POINT_BOTTOM = 3'h0;

  typedef enum logic [1:0] {
    TTCM_IDLE = 2'b00,
    TTCM_MIN_HOLD = 2'b01,
    TTCM_HOLD_HOT = 2'b11,
    TTCM_COOLING = 2'b10
  } ttcm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic lp;
    logic [3:0] idx;
    logic [63:0] wdata;
  } ttcm_msr_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [63:0] rdata;
  } ttcm_msr_rsp_t;

endpackage

// [hdl/ttcm_top.sv]
// thermal throttle, trip status, thermal interrupts and clock duty modulation
//
// Function
// - status bit 0 shows throttling engaged now
// - status bit 1 sticky trip log, software clears
// - stay engaged at least one millisecond after trip
// - then disengage only once cool, with hysteresis
// - hold interrupts while clock gated, never drop
// - control bit 0 enables rising-temperature interrupt
// - control bit 1 enables falling-temperature interrupt
// - reset clears both interrupt enables
// - time stamp advance never gated
// - adaptive throttle steps operating point lower
// - own or peer trip moves both cores
// - trip level fixed, no writable threshold
// - modulation control bit 4 enables software modulation
// - duty from bits 1 to 3, enable gated
// - duty code N runs N eighths, 000 reserved
// - engaged duty throttle overrides software duty
// - per logical processor control, highest duty wins
// - stop clock driven internally, no external pin
// - misc enable bit 3 enables duty throttle
`timescale 1ns/1ps
module ttcm_top #(
  parameter int MIN_ENGAGE_COUNT = ttcm_pkg::MIN_ENGAGE_CYC,
  parameter int ADAPT_STEP_COUNT = ttcm_pkg::ADAPT_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire ttcm_pkg::ttcm_msr_req_t msr_req,
  output ttcm_pkg::ttcm_msr_rsp_t msr_rsp,
  // thermal sensor and peer core
  input wire logic sensor_trip,
  input wire logic peer_engaged,
  output logic engaged_out,
  // interrupt request toward the local vector entry
  output logic therm_irq_req,
  output logic therm_irq_low,
  // core clock gating and time stamp
  output logic core_clk_en,
  output logic tsc_advance,
  // adaptive operating point
  output logic [2:0] op_point
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ttcm_pkg::ttcm_state_t state_r;
  ttcm_pkg::ttcm_state_t state_nxt;
  logic [ttcm_pkg::CNT_W-1:0] hold_cnt_r;
  logic [ttcm_pkg::CNT_W-1:0] hold_cnt_nxt;
  logic trip_log_r;
  logic ie_high_r;
  logic ie_low_r;
  logic duty_thr_en_r;
  logic adapt_en_r;
  logic [ttcm_pkg::NUM_LP-1:0] cm_en_r;
  logic [2:0] cm_duty_r [ttcm_pkg::NUM_LP];
  logic engaged_r;
  logic hi_pend_r;
  logic lo_pend_r;
  logic [ttcm_pkg::CNT_W-1:0] slot_cnt_r;
  logic [2:0] slot_idx_r;
  logic [ttcm_pkg::CNT_W-1:0] step_cnt_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic engaged;
  logic wr_status;
  logic wr_int_ctl;
  logic wr_clk_mod;
  logic wr_misc;
  logic idx_known;
  logic deliver;

  assign engaged = (state_r != ttcm_pkg::TTCM_IDLE);
  assign wr_status = msr_req.wr && (msr_req.idx == ttcm_pkg::IDX_THERM_STATUS);
  assign wr_int_ctl = msr_req.wr && (msr_req.idx == ttcm_pkg::IDX_THERM_INT_CTL);
  assign wr_clk_mod = msr_req.wr && (msr_req.idx == ttcm_pkg::IDX_CLK_MOD_CTL);
  assign wr_misc = msr_req.wr && (msr_req.idx == ttcm_pkg::IDX_MISC_ENABLE);
  assign idx_known = (msr_req.idx == ttcm_pkg::IDX_THERM_STATUS) ||
                     (msr_req.idx == ttcm_pkg::IDX_THERM_INT_CTL) ||
                     (msr_req.idx == ttcm_pkg::IDX_CLK_MOD_CTL) ||
                     (msr_req.idx == ttcm_pkg::IDX_MISC_ENABLE);

  // ----------------------------------------------------------------
  // throttle engagement
  // ----------------------------------------------------------------
  // sensor_trip is the fixed-level comparator; nothing here can move it
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ttcm_pkg::TTCM_IDLE: begin
        hold_cnt_nxt = '0;
        if (sensor_trip) begin
          state_nxt = ttcm_pkg::TTCM_MIN_HOLD;
        end
      end
      ttcm_pkg::TTCM_MIN_HOLD: begin
        hold_cnt_nxt = hold_cnt_r + 1'b1;
        if (hold_cnt_r == ttcm_pkg::CNT_W'(MIN_ENGAGE_COUNT - 1)) begin
          state_nxt = ttcm_pkg::TTCM_HOLD_HOT;
          hold_cnt_nxt = '0;
        end
      end
      ttcm_pkg::TTCM_HOLD_HOT: begin
        hold_cnt_nxt = '0;
        if (!sensor_trip) begin
          state_nxt = ttcm_pkg::TTCM_COOLING;
        end
      end
      ttcm_pkg::TTCM_COOLING: begin
        hold_cnt_nxt = hold_cnt_r + 1'b1;
        if (sensor_trip) begin
          state_nxt = ttcm_pkg::TTCM_HOLD_HOT;
          hold_cnt_nxt = '0;
        end else if (hold_cnt_r == ttcm_pkg::CNT_W'(ttcm_pkg::HYST_CYC - 1)) begin
          state_nxt = ttcm_pkg::TTCM_IDLE;
          hold_cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = ttcm_pkg::TTCM_IDLE;
        hold_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ttcm_pkg::TTCM_IDLE;
      hold_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      engaged_r <= 1'b0;
    end else begin
      engaged_r <= engaged;
    end
  end

  // ----------------------------------------------------------------
  // sticky trip log
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      trip_log_r <= 1'b0;
    end else if (sensor_trip) begin
      trip_log_r <= 1'b1;
    end else if (wr_status && !msr_req.wdata[ttcm_pkg::ST_LOG_BIT]) begin
      trip_log_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ie_high_r <= 1'b0;
      ie_low_r <= 1'b0;
    end else if (wr_int_ctl) begin
      ie_high_r <= msr_req.wdata[ttcm_pkg::IE_HIGH_BIT];
      ie_low_r <= msr_req.wdata[ttcm_pkg::IE_LOW_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      duty_thr_en_r <= 1'b0;
      adapt_en_r <= 1'b0;
    end else if (wr_misc) begin
      duty_thr_en_r <= msr_req.wdata[ttcm_pkg::ME_DUTY_THR_BIT];
      adapt_en_r <= msr_req.wdata[ttcm_pkg::ME_ADAPT_BIT];
    end
  end

  for (genvar g = 0; g < ttcm_pkg::NUM_LP; g++) begin : g_lp
    always_ff @(posedge clk) begin
      if (rst) begin
        cm_en_r[g] <= 1'b0;
        cm_duty_r[g] <= ttcm_pkg::CM_DUTY_RST;
      end else if (wr_clk_mod && (msr_req.lp == 1'(g))) begin
        cm_en_r[g] <= msr_req.wdata[ttcm_pkg::CM_EN_BIT];
        cm_duty_r[g] <= msr_req.wdata[ttcm_pkg::CM_DUTY_LSB +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      msr_rsp <= '0;
    end else begin
      msr_rsp.ack <= msr_req.wr || msr_req.rd;
      msr_rsp.err <= (msr_req.wr || msr_req.rd) && !idx_known;
      msr_rsp.rdata <= '0;
      if (msr_req.rd) begin
        case (msr_req.idx)
          ttcm_pkg::IDX_THERM_STATUS: begin
            msr_rsp.rdata[ttcm_pkg::ST_TRIP_BIT] <= engaged;
            msr_rsp.rdata[ttcm_pkg::ST_LOG_BIT] <= trip_log_r;
          end
          ttcm_pkg::IDX_THERM_INT_CTL: begin
            msr_rsp.rdata[ttcm_pkg::IE_HIGH_BIT] <= ie_high_r;
            msr_rsp.rdata[ttcm_pkg::IE_LOW_BIT] <= ie_low_r;
          end
          ttcm_pkg::IDX_CLK_MOD_CTL: begin
            msr_rsp.rdata[ttcm_pkg::CM_EN_BIT] <= cm_en_r[msr_req.lp];
            msr_rsp.rdata[ttcm_pkg::CM_DUTY_LSB +: 3] <= cm_duty_r[msr_req.lp];
          end
          ttcm_pkg::IDX_MISC_ENABLE: begin
            msr_rsp.rdata[ttcm_pkg::ME_DUTY_THR_BIT] <= duty_thr_en_r;
            msr_rsp.rdata[ttcm_pkg::ME_ADAPT_BIT] <= adapt_en_r;
          end
          default: begin
            msr_rsp.rdata <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // duty selection
  // ----------------------------------------------------------------
  logic sw_on;
  logic [2:0] sw_duty;
  logic mod_active;
  logic [3:0] run_slots;

  always_comb begin
    sw_on = 1'b0;
    sw_duty = 3'h0;
    for (int i = 0; i < ttcm_pkg::NUM_LP; i++) begin
      if (cm_en_r[i]) begin
        sw_on = 1'b1;
        if (cm_duty_r[i] > sw_duty) begin
          sw_duty = cm_duty_r[i];
        end
      end
    end
  end

  always_comb begin
    mod_active = (duty_thr_en_r && engaged) || sw_on;
    if (duty_thr_en_r && engaged) begin
      run_slots = ttcm_pkg::AUTO_DUTY_SLOTS;
    end else if (sw_duty == 3'h0) begin
      run_slots = ttcm_pkg::FULL_SLOTS;
    end else begin
      run_slots = {1'b0, sw_duty};
    end
  end

  // ----------------------------------------------------------------
  // modulation frame and internal stop clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_cnt_r <= '0;
      slot_idx_r <= 3'h0;
    end else if (slot_cnt_r == ttcm_pkg::CNT_W'(ttcm_pkg::SLOT_CYC - 1)) begin
      slot_cnt_r <= '0;
      slot_idx_r <= slot_idx_r + 3'h1;
    end else begin
      slot_cnt_r <= slot_cnt_r + 1'b1;
    end
  end

  // gating is made here only; no external stop clock input exists
  always_ff @(posedge clk) begin
    if (rst) begin
      core_clk_en <= 1'b1;
    end else begin
      core_clk_en <= !mod_active || ({1'b0, slot_idx_r} < run_slots);
    end
  end

  // time stamp keeps counting whatever the gate does
  always_ff @(posedge clk) begin
    if (rst) begin
      tsc_advance <= 1'b0;
    end else begin
      tsc_advance <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // thermal interrupt requests
  // ----------------------------------------------------------------
  assign deliver = core_clk_en && (hi_pend_r || lo_pend_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      hi_pend_r <= 1'b0;
      lo_pend_r <= 1'b0;
    end else begin
      hi_pend_r <= (ie_high_r && engaged && !engaged_r) ||
                   (hi_pend_r && !deliver);
      lo_pend_r <= (ie_low_r && !engaged && engaged_r) ||
                   (lo_pend_r && !(deliver && !hi_pend_r));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      therm_irq_req <= 1'b0;
      therm_irq_low <= 1'b0;
    end else begin
      therm_irq_req <= deliver;
      therm_irq_low <= deliver && !hi_pend_r;
    end
  end

  // ----------------------------------------------------------------
  // adaptive operating point and peer coupling
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      engaged_out <= 1'b0;
    end else begin
      engaged_out <= engaged;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      step_cnt_r <= '0;
      op_point <= ttcm_pkg::OP_POINT_TOP;
    end else if (!adapt_en_r) begin
      step_cnt_r <= '0;
      op_point <= ttcm_pkg::OP_POINT_TOP;
    end else if (step_cnt_r == ttcm_pkg::CNT_W'(ADAPT_STEP_COUNT - 1)) begin
      step_cnt_r <= '0;
      if ((engaged || peer_engaged) && op_point != ttcm_pkg::OP_POINT_BOTTOM) begin
        op_point <= op_point - 3'h1;
      end else if (!engaged && !peer_engaged && op_point != ttcm_pkg::OP_POINT_TOP) begin
        op_point <= op_point + 3'h1;
      end
    end else begin
      step_cnt_r <= step_cnt_r + 1'b1;
    end
  end

endmodule

// [verif/ttcm_properties.sv]
// port assertions for the thermal throttle clock modulator
`timescale 1ns/1ps
module ttcm_properties #(
  parameter int MIN_ENGAGE_COUNT = 20,
  parameter int ADAPT_STEP_COUNT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire ttcm_pkg::ttcm_msr_req_t msr_req,
  input wire ttcm_pkg::ttcm_msr_rsp_t msr_rsp,
  // thermal
  input wire logic sensor_trip,
  input wire logic peer_engaged,
  input wire logic engaged_out,
  // interrupts
  input wire logic therm_irq_req,
  input wire logic therm_irq_low,
  // clocking
  input wire logic core_clk_en,
  input wire logic tsc_advance,
  input wire logic [2:0] op_point
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] eng_cnt_r;
  logic [15:0] low_cnt_r;
  logic [15:0] off_cnt_r;
  logic ie_hi_r;
  logic ie_lo_r;
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    eng_cnt_r <= (rst || !engaged_out) ? 16'h0 : eng_cnt_r + 16'h1;
  end
  always_ff @(posedge clk) begin
    low_cnt_r <= (rst || sensor_trip) ? 16'h0 : low_cnt_r + {15'h0, low_cnt_r != 16'hFFFF};
  end
  always_ff @(posedge clk) begin
    off_cnt_r <= (rst || core_clk_en) ? 16'h0 : off_cnt_r + 16'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ie_hi_r <= 1'h0;
      ie_lo_r <= 1'h0;
    end else if (msr_req.wr && msr_req.idx == ttcm_pkg::IDX_THERM_INT_CTL) begin
      ie_hi_r <= msr_req.wdata[0];
      ie_lo_r <= msr_req.wdata[1];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reg_ack_a: assert property ((msr_req.wr || msr_req.rd) |=> msr_rsp.ack &&
    (msr_rsp.err == ($past(msr_req.idx) > 4'h3))) else $error("register answer wrong");
  engage_fast_a: assert property ($rose(sensor_trip) |-> ##[1:2] engaged_out)
    else $error("trip not engaged");
  min_hold_a: assert property ($fell(engaged_out) |-> eng_cnt_r >= MIN_ENGAGE_COUNT)
    else $error("engaged too short");
  hyst_wait_a: assert property ($fell(engaged_out) |-> low_cnt_r >= 16'h01F4)
    else $error("released before cool wait");
  irq_hold_a: assert property (therm_irq_req |-> $past(core_clk_en))
    else $error("request while clock stopped");
  high_irq_a: assert property ($rose(engaged_out) && ie_hi_r |->
    ##[0:90] (therm_irq_req && !therm_irq_low)) else $error("high request missing");
  low_irq_a: assert property ($fell(engaged_out) && ie_lo_r |->
    ##[0:90] (therm_irq_req && therm_irq_low)) else $error("low request missing");
  irq_gate_a: assert property (therm_irq_req |-> (therm_irq_low ? ie_lo_r : ie_hi_r))
    else $error("request while disabled");
  reset_vals_a: assert property ($fell(rst) |-> op_point == 3'h7 && !engaged_out &&
    core_clk_en && !therm_irq_req && !msr_rsp.ack) else $error("reset values wrong");
  tsc_free_a: assert property (!$past(rst) |-> tsc_advance)
    else $error("time stamp gated");
  adapt_step_a: assert property ($changed(op_point) |-> op_point == 3'h7 ||
    op_point == $past(op_point) - 3'h1 || op_point == $past(op_point) + 3'h1)
    else $error("operating point jumped");
  duty_gap_a: assert property ($rose(core_clk_en) |-> off_cnt_r <= 16'h0046)
    else $error("clock stopped too long");
  cover property ($rose(engaged_out));
  cover property (therm_irq_req && therm_irq_low);
  cover property ($fell(core_clk_en));
endmodule
bind ttcm_top ttcm_properties #(.MIN_ENGAGE_COUNT(MIN_ENGAGE_COUNT),
  .ADAPT_STEP_COUNT(ADAPT_STEP_COUNT)) prop_i (.clk(clk), .rst(rst), .msr_req(msr_req),
  .msr_rsp(msr_rsp), .sensor_trip(sensor_trip), .peer_engaged(peer_engaged),
  .engaged_out(engaged_out), .therm_irq_req(therm_irq_req), .therm_irq_low(therm_irq_low),
  .core_clk_en(core_clk_en), .tsc_advance(tsc_advance), .op_point(op_point));

// [verif/ttcm_vec_model.sv]
// model of the local vector entry receiving thermal requests
`timescale 1ns/1ps
module ttcm_vec_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the block
  input wire logic irq_req,
  input wire logic irq_low,
  // software mask control
  input wire logic unmask,
  // deliveries to the core
  output int hi_cnt,
  output int lo_cnt
);
  logic mask_r;
  always_ff @(posedge clk) begin
    mask_r <= rst ? 1'h1 : !unmask;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
    end else if (irq_req && !mask_r) begin
      hi_cnt <= hi_cnt + (irq_low ? 0 : 1);
      lo_cnt <= lo_cnt + (irq_low ? 1 : 0);
    end
  end
endmodule

// [verif/tb.sv]
// self-checking bench for the thermal throttle clock modulator
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  ttcm_pkg::ttcm_msr_req_t msr_req = '0;
  ttcm_pkg::ttcm_msr_rsp_t msr_rsp;
  ttcm_pkg::ttcm_msr_rsp_t rsp;
  logic sensor_trip = 1'h0;
  logic peer_engaged = 1'h0;
  logic unmask = 1'h0;
  logic engaged_out, therm_irq_req, therm_irq_low, core_clk_en, tsc_advance;
  logic [2:0] op_point;
  logic [2:0] r;
  logic [31:0] lfsr = 32'hA347CD22;
  int hi_cnt, lo_cnt, n, irq_seen = 0, num_errors = 0, total_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (therm_irq_req === 1'h1) irq_seen++;
  ttcm_top #(.MIN_ENGAGE_COUNT(20), .ADAPT_STEP_COUNT(16)) uut (.clk(clk), .rst(rst),
    .msr_req(msr_req), .msr_rsp(msr_rsp), .sensor_trip(sensor_trip),
    .peer_engaged(peer_engaged), .engaged_out(engaged_out), .therm_irq_req(therm_irq_req),
    .therm_irq_low(therm_irq_low), .core_clk_en(core_clk_en), .tsc_advance(tsc_advance),
    .op_point(op_point));
  ttcm_vec_model vec (.clk(clk), .rst(rst), .irq_req(therm_irq_req),
    .irq_low(therm_irq_low), .unmask(unmask), .hi_cnt(hi_cnt), .lo_cnt(lo_cnt));
  // ----------------------------------------------------------------
  // expectation helpers and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_on(input logic [2:0] a, input logic [2:0] b, input logic thr);
    if (thr) return 40;
    if (a == 3'h0 && b == 3'h0) return 80;
    return ((a > b) ? a : b) * 10;
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic reg_acc(input logic w, input logic [3:0] idx, input logic lp,
    input logic [63:0] wd);
    ttcm_pkg::ttcm_msr_req_t q;
    q = '0;
    q.wr = w;
    q.rd = !w;
    q.lp = lp;
    q.idx = idx;
    q.wdata = wd;
    @(posedge clk);
    msr_req <= q;
    @(posedge clk);
    msr_req <= '0;
    @(posedge clk);
    rsp = msr_rsp;
    chk("ack", {63'h0, rsp.ack}, 64'h1);
  endtask
  task automatic wait_eng(input logic v);
    n = 0;
    while (engaged_out !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
      finish_test;
    end
  endtask
  task automatic count_on;
    n = 0;
    repeat (80) @(posedge clk) n += (core_clk_en === 1'h1);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    reg_acc(1'h0, 4'h1, 1'h0, 64'h0);
    chk("int_ctl", rsp.rdata, 64'h0);
    reg_acc(1'h0, 4'h3, 1'h0, 64'h0);
    chk("misc", rsp.rdata, 64'h0);
    reg_acc(1'h0, 4'h2, 1'h1, 64'h0);
    chk("clk_mod", rsp.rdata, 64'h2);
    reg_acc(1'h1, 4'h0, 1'h0, '1);
    reg_acc(1'h0, 4'h0, 1'h0, 64'h0);
    chk("status", rsp.rdata, 64'h0);
    reg_acc(1'h1, 4'hC, 1'h0, '1);
    chk("err", {63'h0, rsp.err}, 64'h1);
    reg_acc(1'h0, 4'hF, 1'h0, 64'h0);
    chk("unmapped", rsp.rdata, 64'h0);
    // short trip with both interrupts enabled and the entry unmasked
    reg_acc(1'h1, 4'h1, 1'h0, 64'h3);
    unmask <= 1'h1;
    sensor_trip <= 1'h1;
    repeat (2) @(posedge clk);
    sensor_trip <= 1'h0;
    wait_eng(1'h1);
    reg_acc(1'h0, 4'h0, 1'h0, 64'h0);
    chk("status_hot", rsp.rdata, 64'h3);
    wait_eng(1'h0);
    chk("eng_len", {63'h0, n >= 490 && n <= 530}, 64'h1);
    reg_acc(1'h0, 4'h0, 1'h0, 64'h0);
    chk("log", rsp.rdata, 64'h2);
    reg_acc(1'h1, 4'h0, 1'h0, 64'h0);
    reg_acc(1'h0, 4'h0, 1'h0, 64'h0);
    chk("log_clr", rsp.rdata, 64'h0);
    chk("hi_del", hi_cnt, 1);
    chk("lo_del", lo_cnt, 1);
    // masked entry, low-temperature interrupt disabled
    unmask <= 1'h0;
    reg_acc(1'h1, 4'h1, 1'h0, 64'h1);
    sensor_trip <= 1'h1;
    repeat (30) @(posedge clk);
    sensor_trip <= 1'h0;
    wait_eng(1'h0);
    repeat (4) @(posedge clk);
    chk("irq_count", irq_seen, 3);
    chk("masked", hi_cnt, 1);
    // software duty codes on both logical processors, random partner code
    for (int c = 0; c < 8; c++) begin
      lfsr = lfsr_next(lfsr);
      r = (c == 0) ? 3'h0 : ((lfsr[2:0] == 3'h0) ? 3'h1 : lfsr[2:0]);
      reg_acc(1'h1, 4'h2, 1'h0, {59'h0, 1'h1, c[2:0], 1'h0});
      reg_acc(1'h1, 4'h2, 1'h1, {59'h0, 1'h1, r, 1'h0});
      repeat (90) @(posedge clk);
      count_on;
      chk("duty_on", n, exp_on(c[2:0], r, 1'h0));
    end
    reg_acc(1'h1, 4'h2, 1'h0, 64'hA);
    reg_acc(1'h1, 4'h2, 1'h1, 64'hA);
    repeat (90) @(posedge clk);
    count_on;
    chk("duty_off", n, 80);
    // engaged duty throttle overrides software duty
    reg_acc(1'h1, 4'h2, 1'h0, 64'h12);
    reg_acc(1'h1, 4'h3, 1'h0, 64'h8);
    sensor_trip <= 1'h1;
    wait_eng(1'h1);
    repeat (90) @(posedge clk);
    count_on;
    chk("thr_on", n, exp_on(3'h1, 3'h1, 1'h1));
    chk("tsc", {63'h0, tsc_advance}, 64'h1);
    sensor_trip <= 1'h0;
    wait_eng(1'h0);
    chk("irq_gated", irq_seen, 4);
    // adaptive stepping driven by the peer core
    reg_acc(1'h1, 4'h3, 1'h0, 64'h10000);
    peer_engaged <= 1'h1;
    repeat (64) @(posedge clk);
    chk("adapt_dn", {63'h0, op_point <= 3'h4 && op_point >= 3'h2}, 64'h1);
    peer_engaged <= 1'h0;
    repeat (140) @(posedge clk);
    chk("adapt_up", op_point, 64'h7);
    finish_test;
  end
endmodule
